// ### design/clk_ctrl_pkg.sv
// Package with constants, encodings and carriers for the clock controller
package clk_ctrl_pkg;
	// Oscillator source codes
	localparam logic [2:0] SRC_FRC = 3'h0;
	localparam logic [2:0] SRC_FRC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRI = 3'h2;
	localparam logic [2:0] SRC_PRI_PLL = 3'h3;
	localparam logic [2:0] SRC_SEC = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
	localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
	localparam logic [2:0] SRC_FRC_DIVN = 3'h7;
	// Control register field positions
	localparam int CUR_LSB = 12;
	localparam int NEXT_LSB = 8;
	localparam int LOCK_BIT = 5;
	localparam int FAIL_BIT = 3;
	localparam int SEC_EN_BIT = 1;
	localparam int SWREQ_BIT = 0;
	// Unlock key bytes, arbitrary values
	localparam logic [7:0] KEY_HI_1 = 8'h78;
	localparam logic [7:0] KEY_HI_2 = 8'h9A;
	localparam logic [7:0] KEY_LO_1 = 8'h46;
	localparam logic [7:0] KEY_LO_2 = 8'h57;
	// Reset values and timing
	localparam logic [2:0] RST_SRC = 3'h0;
	localparam int HANDOVER_CYCLES = 10;
	localparam int WAKE_MIN_CYCLES = 2;
	localparam int WAKE_MAX_CYCLES = 4;
	localparam logic [2:0] WAKE_CYCLES = 3'h3;
	// Power-save operands
	localparam logic PS_SLEEP = 1'b0;
	localparam logic PS_IDLE = 1'b1;
	// Oscillator enables, one per source kind
	typedef struct packed {
		logic fast_rc_osc;
		logic pri;
		logic sec;
		logic low_power_rc_osc;
		logic pll;
	} osc_en_t;
	// Wake-up causes
	typedef struct packed {
		logic irq;
		logic dev_reset;
		logic wdt_timeout;
	} wake_t;
	function automatic logic uses_pll(input logic [2:0] s);
		return (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
	endfunction
	function automatic logic is_crystal(input logic [2:0] s);
		return (s == SRC_PRI) || (s == SRC_PRI_PLL) || (s == SRC_SEC);
	endfunction
	function automatic osc_en_t src_osc(input logic [2:0] s);
		osc_en_t e;
		e = '0;
		case (s)
			SRC_PRI, SRC_PRI_PLL: e.pri = 1'b1;
			SRC_SEC: e.sec = 1'b1;
			SRC_LOW_POWER_RC_OSC: e.low_power_rc_osc = 1'b1;
			default: e.fast_rc_osc = 1'b1;
		endcase
		e.pll = uses_pll(s);
		return e;
	endfunction
endpackage

// ### design/clock_switch_and_power_save.sv
// Clock switch, failure fallback and Sleep/Idle controller
`timescale 1ns/1ps
module clock_switch_and_power_save
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Configuration
	input wire logic switch_monitor_config_bit,
	input wire logic [2:0] cfg_start_src,
	input wire logic wdt_enabled,
	// Unlock key writes
	input wire logic key_we,
	input wire logic [7:0] key_data,
	// Protected control writes
	input wire logic hi_we,
	input wire logic [2:0] hi_next_src,
	input wire logic lo_we,
	input wire logic lo_switch_req,
	input wire logic lo_sec_en,
	input wire logic lo_fail_clr,
	// Oscillator status
	input wire logic crystal_startup_timer_done,
	input wire logic pll_locked,
	input wire logic new_clk_tick,
	input wire logic osc_failed,
	// Power-save instruction and wake sources
	input wire logic power_save_instruction,
	input wire logic ps_operand,
	input wire clk_ctrl_pkg::wake_t wake,
	// Control register view
	output logic [2:0] current_source_field,
	output logic [2:0] next_source_field,
	output logic switch_request_bit,
	output logic clock_fail_flag,
	output logic lock_flag,
	output logic secondary_osc_enable,
	// Oscillator and clock controls
	output clk_ctrl_pkg::osc_en_t osc_en,
	output logic [2:0] sys_clk_sel,
	output logic sys_clk_run,
	output logic cpu_clk_run,
	output logic periph_clk_run,
	output logic monitor_active,
	output logic wdt_clear,
	output logic fail_trap,
	output logic cpu_stall
);
	////////////////////////////////////////////////////////////////////
	// Unlock gates for high and low bytes
	logic hi_open, lo_open, hi_ok, lo_ok, sw_enabled;
	unlock_gate u_hi
	(
		.mclk(mclk),
		.rst(rst),
		.key_we(key_we),
		.key_data(key_data),
		.prot_we(hi_we),
		.key1(clk_ctrl_pkg::KEY_HI_1),
		.key2(clk_ctrl_pkg::KEY_HI_2),
		.open_now(hi_open)
	);
	unlock_gate u_lo
	(
		.mclk(mclk),
		.rst(rst),
		.key_we(key_we),
		.key_data(key_data),
		.prot_we(lo_we),
		.key1(clk_ctrl_pkg::KEY_LO_1),
		.key2(clk_ctrl_pkg::KEY_LO_2),
		.open_now(lo_open)
	);
	assign hi_ok = hi_we && hi_open;
	assign lo_ok = lo_we && lo_open;
	assign sw_enabled = !switch_monitor_config_bit;

	////////////////////////////////////////////////////////////////////
	// Switch and power state machines
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_START = 5'b00010,
		S_LOCK = 5'b00100,
		S_COUNT = 5'b01000,
		S_DONE = 5'b10000
	} sw_state_t;
	typedef enum logic [2:0] {
		P_RUN = 3'b001,
		P_SLEEP = 3'b010,
		P_IDLE = 3'b100
	} pw_state_t;

	sw_state_t sw_q, sw_d;
	pw_state_t pw_q, pw_d;
	logic [2:0] cur_q, cur_d, nxt_q, nxt_d, tgt_q, tgt_d;
	logic req_q, req_d, fail_q, fail_d, lock_q, lock_d, sec_q, sec_d;
	logic [3:0] cnt_q, cnt_d;
	logic [2:0] wk_q, wk_d;
	logic waking_q, waking_d, init_q, init_d;
	logic start_sw, any_wake, fail_evt, in_sleep;

	assign any_wake = wake.irq || wake.dev_reset || wake.wdt_timeout;
	assign in_sleep = (pw_q == P_SLEEP);
	assign monitor_active = sw_enabled && !in_sleep && init_q;
	assign fail_evt = monitor_active && osc_failed;
	assign start_sw = (sw_q == S_IDLE) && req_q && !fail_evt;

	function automatic logic uses_pll_now(input logic [2:0] t, input sw_state_t s);
		return clk_ctrl_pkg::uses_pll(t) && (s != S_IDLE);
	endfunction

	always_comb
	begin
		sw_d = sw_q;
		pw_d = pw_q;
		cur_d = cur_q;
		nxt_d = nxt_q;
		tgt_d = tgt_q;
		req_d = req_q;
		fail_d = fail_q;
		lock_d = lock_q;
		sec_d = sec_q;
		cnt_d = cnt_q;
		wk_d = wk_q;
		waking_d = waking_q;
		init_d = 1'b1;
		// Configured start source caught after reset release
		if (!init_q)
		begin
			cur_d = cfg_start_src;
			nxt_d = cfg_start_src;
		end
		if (hi_ok && sw_enabled)
			nxt_d = hi_next_src;
		if (lo_ok)
		begin
			sec_d = lo_sec_en;
			if (lo_switch_req && sw_enabled)
				req_d = 1'b1;
			if (lo_fail_clr)
				fail_d = 1'b0;
		end
		if (pll_locked && uses_pll_now(tgt_q, sw_q))
			lock_d = 1'b1;
		case (sw_q)
			S_IDLE:
			begin
				if (start_sw)
				begin
					if (cur_q == nxt_q)
						req_d = 1'b0;
					else
					begin
						lock_d = 1'b0;
						fail_d = 1'b0;
						tgt_d = nxt_q;
						sw_d = S_START;
					end
				end
			end
			S_START:
			begin
				if (!clk_ctrl_pkg::is_crystal(tgt_q) || crystal_startup_timer_done)
					sw_d = S_LOCK;
			end
			S_LOCK:
			begin
				if (!clk_ctrl_pkg::uses_pll(tgt_q) || lock_q)
				begin
					cnt_d = 4'h0;
					sw_d = S_COUNT;
				end
			end
			S_COUNT:
			begin
				if (new_clk_tick)
				begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == 4'(clk_ctrl_pkg::HANDOVER_CYCLES - 1))
						sw_d = S_DONE;
				end
			end
			S_DONE:
			begin
				req_d = 1'b0;
				cur_d = tgt_q;
				sw_d = S_IDLE;
			end
			default: sw_d = S_IDLE;
		endcase
		// failure falls back to fast RC
		if (fail_evt)
		begin
			fail_d = 1'b1;
			cur_d = clk_ctrl_pkg::uses_pll(cur_q) ? clk_ctrl_pkg::SRC_FRC_PLL
				: clk_ctrl_pkg::SRC_FRC;
			nxt_d = cur_d;
			req_d = 1'b0;
			sw_d = S_IDLE;
		end
		if (!sw_enabled)
		begin
			req_d = 1'b0;
			sw_d = S_IDLE;
		end
		case (pw_q)
			P_RUN:
			begin
				waking_d = 1'b0;
				if (power_save_instruction)
					pw_d = (ps_operand == clk_ctrl_pkg::PS_SLEEP) ? P_SLEEP : P_IDLE;
			end
			P_SLEEP:
			begin
				if (any_wake)
					pw_d = P_RUN;
			end
			P_IDLE:
			begin
				if (waking_q)
				begin
					wk_d = wk_q - 3'h1;
					if (wk_q == 3'h1)
						pw_d = P_RUN;
				end
				else if (any_wake)
				begin
					waking_d = 1'b1;
					wk_d = clk_ctrl_pkg::WAKE_CYCLES;
				end
			end
			default: pw_d = P_RUN;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			sw_q <= S_IDLE;
			pw_q <= P_RUN;
			cur_q <= clk_ctrl_pkg::RST_SRC;
			nxt_q <= clk_ctrl_pkg::RST_SRC;
			tgt_q <= clk_ctrl_pkg::RST_SRC;
			req_q <= 1'b0;
			fail_q <= 1'b0;
			lock_q <= 1'b0;
			sec_q <= 1'b0;
			cnt_q <= 4'h0;
			wk_q <= 3'h0;
			waking_q <= 1'b0;
			init_q <= 1'b0;
		end
		else
		begin
			sw_q <= sw_d;
			pw_q <= pw_d;
			cur_q <= cur_d;
			nxt_q <= nxt_d;
			tgt_q <= tgt_d;
			req_q <= req_d;
			fail_q <= fail_d;
			lock_q <= lock_d;
			sec_q <= sec_d;
			cnt_q <= cnt_d;
			wk_q <= wk_d;
			waking_q <= waking_d;
			init_q <= init_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Oscillator enables and clock gating
	clk_ctrl_pkg::osc_en_t run_en, tgt_en;
	always_comb
	begin
		run_en = clk_ctrl_pkg::src_osc(cur_q);
		tgt_en = (sw_q != S_IDLE) ? clk_ctrl_pkg::src_osc(tgt_q) : '0;
		osc_en = run_en | tgt_en;
		if (in_sleep)
			osc_en = '0;
		// watchdog keeps low-power RC in Sleep
		osc_en.low_power_rc_osc = osc_en.low_power_rc_osc || wdt_enabled || monitor_active;
		osc_en.sec = osc_en.sec || sec_q;
	end

	assign current_source_field = cur_q;
	assign next_source_field = nxt_q;
	assign switch_request_bit = req_q;
	assign clock_fail_flag = fail_q;
	assign lock_flag = lock_q;
	assign secondary_osc_enable = sec_q;
	assign sys_clk_sel = cur_q;
	// Sleep stops system clock, Idle keeps it
	assign sys_clk_run = !in_sleep;
	assign periph_clk_run = !in_sleep;
	assign cpu_clk_run = (pw_q == P_RUN);
	assign cpu_stall = 1'b0;
	assign wdt_clear = (pw_q == P_RUN) && power_save_instruction;
	assign fail_trap = fail_evt;

	////////////////////////////////////////////////////////////////////
	// Checks
	chk_abort_equal: assert property (@(posedge mclk) disable iff (rst)
		start_sw && cur_q == nxt_q && sw_enabled |=> !req_q && sw_q == S_IDLE)
		else $error("redundant switch not aborted");
	chk_flags_clear: assert property (@(posedge mclk) disable iff (rst)
		start_sw && cur_q != nxt_q && sw_enabled |=> !lock_q && !fail_q)
		else $error("flags not cleared at switch start");
	chk_crystal_wait: assert property (@(posedge mclk) disable iff (rst)
		sw_q == S_START && clk_ctrl_pkg::is_crystal(tgt_q) && !crystal_startup_timer_done
		&& !fail_evt && sw_enabled |=> sw_q == S_START)
		else $error("crystal start-up wait skipped");
	chk_pll_hold: assert property (@(posedge mclk) disable iff (rst)
		sw_q == S_LOCK && clk_ctrl_pkg::uses_pll(tgt_q) && !lock_q |=> sw_q != S_COUNT)
		else $error("switch passed without PLL lock");
	chk_ten_ticks: assert property (@(posedge mclk) disable iff (rst)
		sw_q == S_DONE |-> $past(cnt_q) == 4'(clk_ctrl_pkg::HANDOVER_CYCLES - 1))
		else $error("handover before ten cycles");
	chk_done_copy: assert property (@(posedge mclk) disable iff (rst)
		sw_q == S_DONE && !fail_evt && sw_enabled |=> !req_q && cur_q == $past(tgt_q))
		else $error("completion did not update fields");
	chk_fallback_frc: assert property (@(posedge mclk) disable iff (rst)
		fail_evt |=> clock_fail_flag && (cur_q == clk_ctrl_pkg::SRC_FRC
		|| cur_q == clk_ctrl_pkg::SRC_FRC_PLL))
		else $error("no fallback to fast RC");
	chk_fallback_pll: assert property (@(posedge mclk) disable iff (rst)
		fail_evt && clk_ctrl_pkg::uses_pll(cur_q) |=> cur_q == clk_ctrl_pkg::SRC_FRC_PLL)
		else $error("PLL dropped on fallback");
	chk_req_disabled: assert property (@(posedge mclk) disable iff (rst)
		switch_monitor_config_bit |=> !req_q)
		else $error("request set while switching disabled");
	chk_idle_wake: assert property (@(posedge mclk) disable iff (rst)
		pw_q == P_IDLE && !waking_q && any_wake |-> ##[2:4] cpu_clk_run)
		else $error("Idle wake delay out of range");
	chk_sleep_src: assert property (@(posedge mclk) disable iff (rst)
		in_sleep && any_wake |=> cur_q == $past(cur_q))
		else $error("source changed across Sleep");
	cov_switch: cover property (@(posedge mclk) disable iff (rst) sw_q == S_DONE);
	cov_fail: cover property (@(posedge mclk) disable iff (rst) fail_evt);
	cov_sleep: cover property (@(posedge mclk) disable iff (rst) in_sleep ##1 !in_sleep);
	cov_idle: cover property (@(posedge mclk) disable iff (rst) pw_q == P_IDLE && waking_q);
endmodule

// ### design/unlock_gate.sv
// Unlock sequence detector gating one protected write
`timescale 1ns/1ps
module unlock_gate
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Key write strobe and data
	input wire logic key_we,
	input wire logic [7:0] key_data,
	// Protected write strobe
	input wire logic prot_we,
	// Keys for this byte
	input wire logic [7:0] key1,
	input wire logic [7:0] key2,
	// Write allowed in this cycle
	output logic open_now
);
	typedef enum logic [2:0] {
		U_IDLE = 3'b001,
		U_KEY1 = 3'b010,
		U_OPEN = 3'b100
	} ustate_t;
	ustate_t st_q, st_d;

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			U_IDLE: if (key_we && key_data == key1) st_d = U_KEY1;
			U_KEY1: st_d = (key_we && key_data == key2) ? U_OPEN : U_IDLE;
			U_OPEN: st_d = (key_we && key_data == key1) ? U_KEY1 : U_IDLE;
			default: st_d = U_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st_q <= U_IDLE;
		else
			st_q <= st_d;
	end

	assign open_now = (st_q == U_OPEN) && !key_we;

	chk_open_after_keys: assert property (@(posedge mclk) disable iff (rst)
		open_now |-> $past(st_q == U_KEY1))
		else $error("protected write window without key pair");
endmodule

// ### test/clock_switch_and_power_save_bench.sv
// Self-checking bench for the clock switch and power-save controller
`timescale 1ns/1ps
module clock_switch_and_power_save_bench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cfg_bit = 1'b0;
	logic [2:0] start_src = clk_ctrl_pkg::SRC_FRC;
	logic wdt_en = 1'b0;
	logic key_we = 1'b0;
	logic [7:0] key_data = 8'h00;
	logic hi_we = 1'b0;
	logic [2:0] hi_src = 3'h0;
	logic lo_we = 1'b0;
	logic lo_req = 1'b0;
	logic lo_sec = 1'b0;
	logic lo_clr = 1'b0;
	logic xt_done = 1'b0;
	logic pll_lk = 1'b0;
	logic tck = 1'b0;
	logic failed = 1'b0;
	logic ps = 1'b0;
	logic ps_op = 1'b0;
	clk_ctrl_pkg::wake_t wake = '0;
	logic [2:0] cur, nxt, sel;
	logic req, fail_flag, lock, sec_en, sys_run, cpu_run, per_run, mon, wclr, trap, stall;
	clk_ctrl_pkg::osc_en_t osc_en;
	int n_fail = 0;
	int num_checks = 0;
	int n;
	////////////////////////////////////////////////////////////////
	always #50 mclk = ~mclk;
	clock_switch_and_power_save DUT
	(
		.mclk(mclk), .rst(rst), .switch_monitor_config_bit(cfg_bit), .cfg_start_src(start_src),
		.wdt_enabled(wdt_en), .key_we(key_we), .key_data(key_data), .hi_we(hi_we),
		.hi_next_src(hi_src), .lo_we(lo_we), .lo_switch_req(lo_req), .lo_sec_en(lo_sec),
		.lo_fail_clr(lo_clr), .crystal_startup_timer_done(xt_done), .pll_locked(pll_lk),
		.new_clk_tick(tck), .osc_failed(failed), .power_save_instruction(ps),
		.ps_operand(ps_op), .wake(wake), .current_source_field(cur), .next_source_field(nxt),
		.switch_request_bit(req), .clock_fail_flag(fail_flag), .lock_flag(lock),
		.secondary_osc_enable(sec_en), .osc_en(osc_en), .sys_clk_sel(sel),
		.sys_clk_run(sys_run), .cpu_clk_run(cpu_run), .periph_clk_run(per_run),
		.monitor_active(mon), .wdt_clear(wclr), .fail_trap(trap), .cpu_stall(stall)
	);
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask
	task automatic unlock(input logic [7:0] k1, input logic [7:0] k2);
		key_we = 1'b1;
		key_data = k1;
		cyc(1);
		key_data = k2;
		cyc(1);
		key_we = 1'b0;
	endtask
	task automatic wr_hi(input logic [2:0] s);
		unlock(clk_ctrl_pkg::KEY_HI_1, clk_ctrl_pkg::KEY_HI_2);
		hi_we = 1'b1;
		hi_src = s;
		cyc(1);
		hi_we = 1'b0;
		cyc(1);
	endtask
	task automatic wr_lo(input logic r, input logic s, input logic c);
		unlock(clk_ctrl_pkg::KEY_LO_1, clk_ctrl_pkg::KEY_LO_2);
		lo_we = 1'b1;
		lo_req = r;
		lo_sec = s;
		lo_clr = c;
		cyc(1);
		lo_we = 1'b0;
		cyc(1);
	endtask
	task automatic tick(input int k);
		repeat (k)
		begin
			tck = 1'b1;
			cyc(1);
			tck = 1'b0;
			cyc(1);
		end
	endtask
	task automatic wait_done();
		for (int i = 0; i < 20; i++)
		begin
			if (req === 1'b0)
				return;
			cyc(1);
		end
		n_fail++;
		$display("BAD switch completion expected 0 seen %b", req);
		test_done();
	endtask
	task automatic sw(input logic [2:0] s);
		wr_hi(s);
		wr_lo(1'b1, 1'b0, 1'b0);
		cyc(3);
	endtask
	task automatic finish_sw(input logic [2:0] s);
		tick(9);
		chk("request at nine ticks", 8'h01, req);
		tick(1);
		wait_done();
		chk("current after switch", s, cur);
		chk("clock select", s, sel);
	endtask
	task automatic do_reset(input logic [2:0] s);
		start_src = s;
		rst = 1'b1;
		cyc(5);
		rst = 1'b0;
		cyc(2);
		chk("current after reset", s, cur);
		chk("request after reset", 8'h00, req);
	endtask
	task automatic sleep_enter(input logic op);
		ps = 1'b1;
		ps_op = op;
		#1;
		chk("watchdog clear", 8'h01, wclr);
		cyc(1);
		ps = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		do_reset(clk_ctrl_pkg::SRC_FRC);
		hi_we = 1'b1;
		hi_src = clk_ctrl_pkg::SRC_PRI;
		cyc(1);
		hi_we = 1'b0;
		cyc(1);
		chk("unlocked-less write", clk_ctrl_pkg::SRC_FRC, nxt);
		unlock(clk_ctrl_pkg::KEY_HI_1, clk_ctrl_pkg::KEY_HI_2);
		cyc(1);
		hi_we = 1'b1;
		hi_src = clk_ctrl_pkg::SRC_PRI;
		cyc(1);
		hi_we = 1'b0;
		cyc(1);
		chk("late protected write", clk_ctrl_pkg::SRC_FRC, nxt);
		sw(clk_ctrl_pkg::SRC_FRC);
		chk("redundant request", 8'h00, req);
		chk("redundant current", clk_ctrl_pkg::SRC_FRC, cur);
		$display("test protect_and_redundant done");
		sw(clk_ctrl_pkg::SRC_PRI);
		chk("crystal enabled", 8'h01, osc_en.pri);
		tick(12);
		chk("held for crystal", 8'h01, req);
		chk("stall", 8'h00, stall);
		xt_done = 1'b1;
		cyc(2);
		finish_sw(clk_ctrl_pkg::SRC_PRI);
		chk("old fast rc off", 8'h00, osc_en.fast_rc_osc);
		chk("low-power rc kept", 8'h01, osc_en.low_power_rc_osc);
		$display("test crystal_switch done");
		sw(clk_ctrl_pkg::SRC_PRI_PLL);
		tick(12);
		chk("held for lock", 8'h01, req);
		chk("lock flag low", 8'h00, lock);
		pll_lk = 1'b1;
		cyc(3);
		chk("lock flag high", 8'h01, lock);
		finish_sw(clk_ctrl_pkg::SRC_PRI_PLL);
		chk("pll on", 8'h01, osc_en.pll);
		$display("test pll_switch done");
		failed = 1'b1;
		#1;
		chk("fail trap", 8'h01, trap);
		cyc(1);
		failed = 1'b0;
		chk("fail flag set", 8'h01, fail_flag);
		chk("fallback source", clk_ctrl_pkg::SRC_FRC_PLL, cur);
		lo_we = 1'b1;
		lo_clr = 1'b1;
		cyc(1);
		lo_we = 1'b0;
		cyc(1);
		chk("flag kept", 8'h01, fail_flag);
		wr_lo(1'b0, 1'b1, 1'b1);
		chk("flag cleared", 8'h00, fail_flag);
		chk("secondary enable", 8'h01, sec_en);
		chk("secondary kept", 8'h01, osc_en.sec);
		failed = 1'b1;
		cyc(1);
		failed = 1'b0;
		sw(clk_ctrl_pkg::SRC_FRC);
		chk("start clears fail", 8'h00, fail_flag);
		chk("start clears lock", 8'h00, lock);
		finish_sw(clk_ctrl_pkg::SRC_FRC);
		$display("test failure_fallback done");
		wdt_en = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			sleep_enter(clk_ctrl_pkg::PS_SLEEP);
			chk("sleep system clock", 8'h00, sys_run);
			chk("sleep cpu clock", 8'h00, cpu_run);
			chk("sleep peripherals", 8'h00, per_run);
			chk("sleep monitor", 8'h00, mon);
			chk("sleep source off", 8'h00, osc_en.fast_rc_osc);
			chk("sleep low-power rc", 8'h01, osc_en.low_power_rc_osc);
			wake = clk_ctrl_pkg::wake_t'(3'h4 >> i);
			cyc(1);
			wake = '0;
			chk("sleep wake", 8'h01, sys_run);
			chk("sleep wake source", clk_ctrl_pkg::SRC_FRC, cur);
			cyc(4);
		end
		$display("test sleep done");
		sleep_enter(clk_ctrl_pkg::PS_IDLE);
		chk("idle cpu", 8'h00, cpu_run);
		chk("idle system clock", 8'h01, sys_run);
		chk("idle peripherals", 8'h01, per_run);
		chk("idle low-power rc", 8'h01, osc_en.low_power_rc_osc);
		cyc(3);
		wake.irq = 1'b1;
		n = 0;
		while (cpu_run !== 1'b1 && n < 10)
		begin
			cyc(1);
			n++;
		end
		wake = '0;
		if (n >= 10)
		begin
			n_fail++;
			$display("BAD idle wake expected 1 seen %b", cpu_run);
			test_done();
		end
		chk("idle wake delay", 8'h01, (n >= clk_ctrl_pkg::WAKE_MIN_CYCLES
			&& n <= clk_ctrl_pkg::WAKE_MAX_CYCLES));
		$display("test idle done");
		cfg_bit = 1'b1;
		cyc(2);
		sw(clk_ctrl_pkg::SRC_PRI);
		chk("disabled request", 8'h00, req);
		chk("disabled current", clk_ctrl_pkg::SRC_FRC, cur);
		chk("disabled monitor", 8'h00, mon);
		failed = 1'b1;
		#1;
		chk("disabled trap", 8'h00, trap);
		cyc(1);
		failed = 1'b0;
		do_reset(clk_ctrl_pkg::SRC_LOW_POWER_RC_OSC);
		$display("test config_disabled done");
		test_done();
	end
endmodule
